// ### include/spe_pkg.sv
`default_nettype none
package spe_pkg;
  localparam int unsigned KEY_W = 32;
  localparam int unsigned KEY_CNT_W = 6;
  // key value is arbitrary, not taken from any real part
  localparam logic [KEY_W-1:0] ENTRY_KEY = 32'h5a3c_96e1;
  localparam logic [KEY_CNT_W-1:0] KEY_LAST = 6'h1f;
  localparam int unsigned SER_W = 16;
  localparam int unsigned SER_CNT_W = 4;
  localparam logic [SER_CNT_W-1:0] SER_LAST = 4'hf;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic [1:0] SYNC_RST_MASTER_CLEAR_PIN = 2'h3;
  typedef enum logic [2:0] {
    SPE_NORMAL,
    SPE_KEY_SHIFT,
    SPE_KEY_FAIL,
    SPE_PROG_LV,
    SPE_PROG_HV
  } spe_state_e;
endpackage
`default_nettype wire

// ### include/spe_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface spe_link_if;
  logic clk_rise;
  logic clk_fall;
  logic clk_level;
  logic data_level;
  logic master_clear_pin_low;
  logic hv_high;
  modport sampler (output clk_rise, clk_fall, clk_level, data_level,
                   master_clear_pin_low, hv_high);
  modport entry (input clk_rise, clk_fall, clk_level, data_level,
                 master_clear_pin_low, hv_high);
endinterface
`default_nettype wire

// ### rtl/spe_link_sampler.sv
`timescale 1ns/100ps
`default_nettype none
module spe_link_sampler (
  input  wire logic   clk_in,
  input  wire logic   resetn_in,
  input  wire logic   prog_clock_pin_in,
  input  wire logic   prog_data_pin_in,
  input  wire logic   master_clear_pin_in,
  input  wire logic   high_programming_voltage_level_in,
  spe_link_if.sampler link
);
  logic [1:0] clk_sync_r;
  logic [1:0] dat_sync_r;
  logic [1:0] master_clear_pin_sync_r;
  logic [1:0] hv_sync_r;
  logic       clk_prev_r;
  logic [1:0] clk_sync_nxt;
  logic [1:0] dat_sync_nxt;
  logic [1:0] master_clear_pin_sync_nxt;
  logic [1:0] hv_sync_nxt;

  // two-flop synchronisers; only stage 2 (bit 1) is read by logic
  always_comb begin
    clk_sync_nxt  = {clk_sync_r[0], prog_clock_pin_in};
    dat_sync_nxt  = {dat_sync_r[0], prog_data_pin_in};
    master_clear_pin_sync_nxt = {master_clear_pin_sync_r[0], master_clear_pin_in};
    hv_sync_nxt   = {hv_sync_r[0], high_programming_voltage_level_in};
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_sync_r  <= spe_pkg::SYNC_RST;
      dat_sync_r  <= spe_pkg::SYNC_RST;
      master_clear_pin_sync_r <= spe_pkg::SYNC_RST_MASTER_CLEAR_PIN;
      hv_sync_r   <= spe_pkg::SYNC_RST;
      clk_prev_r  <= 1'b0;
    end else begin
      clk_sync_r  <= clk_sync_nxt;
      dat_sync_r  <= dat_sync_nxt;
      master_clear_pin_sync_r <= master_clear_pin_sync_nxt;
      hv_sync_r   <= hv_sync_nxt;
      clk_prev_r  <= clk_sync_r[1];
    end
  end

  assign link.clk_level  = clk_sync_r[1];
  assign link.clk_rise   = clk_sync_r[1] & ~clk_prev_r;
  assign link.clk_fall   = ~clk_sync_r[1] & clk_prev_r;
  assign link.data_level = dat_sync_r[1];
  assign link.master_clear_pin_low   = ~master_clear_pin_sync_r[1];
  assign link.hv_high    = hv_sync_r[1];
endmodule
`default_nettype wire

// ### rtl/spe_entry.sv
// Function
// - low-voltage entry is accepted only while the entry enable bit is 1.
// - low-voltage entry: master clear low, then 32 key bits, one per clock.
// - after the key the session lasts only while master clear stays low.
// - an entry enable bit of 1 forces the master clear reset function on.
// - the entry enable bit may be cleared only in a high-voltage session.
// - high-voltage entry needs clock and data low while high voltage is present, and is taken only from the normal state.
// - in session the data pin is bidirectional and the clock pin is input only.
// - in session words are shifted in and read back over clock and data.
`timescale 1ns/100ps
`default_nettype none
module spe_entry (
  input  wire logic                     clk_in,
  input  wire logic                     resetn_in,
  input  wire logic                     prog_clock_pin_in,
  input  wire logic                     prog_data_pin_in,
  input  wire logic                     master_clear_pin_in,
  input  wire logic                     high_programming_voltage_level_in,
  input  wire logic                     low_voltage_entry_enable_in,
  input  wire logic                     cfg_master_clear_pin_reset_enable_in,
  input  wire logic                     lve_clear_req_in,
  input  wire logic                     tx_load_in,
  input  wire logic [spe_pkg::SER_W-1:0] tx_word_in,
  output logic                          prog_data_pin_out,
  output logic                          prog_data_pin_oe_out,
  output logic                          prog_mode_out,
  output logic                          lv_session_out,
  output logic                          hv_session_out,
  output logic                          master_clear_pin_reset_enable_out,
  output logic                          lve_clear_grant_out,
  output logic                          key_reject_out,
  output logic [spe_pkg::SER_W-1:0]     rx_word_out,
  output logic                          rx_valid_out,
  output logic                          tx_busy_out
);
  spe_link_if link ();

  spe_link_sampler u_sampler (
    .clk_in                            (clk_in),
    .resetn_in                         (resetn_in),
    .prog_clock_pin_in                 (prog_clock_pin_in),
    .prog_data_pin_in                  (prog_data_pin_in),
    .master_clear_pin_in               (master_clear_pin_in),
    .high_programming_voltage_level_in (high_programming_voltage_level_in),
    .link                              (link.sampler)
  );

  spe_pkg::spe_state_e                state_r, state_nxt;
  logic [spe_pkg::KEY_W-1:0]          key_sh_r, key_sh_nxt;
  logic [spe_pkg::KEY_CNT_W-1:0]      key_cnt_r, key_cnt_nxt;
  logic [spe_pkg::SER_W-1:0]          rx_sh_r, rx_sh_nxt;
  logic [spe_pkg::SER_CNT_W-1:0]      rx_cnt_r, rx_cnt_nxt;
  logic [spe_pkg::SER_W-1:0]          tx_sh_r, tx_sh_nxt;
  logic [spe_pkg::SER_CNT_W-1:0]      tx_cnt_r, tx_cnt_nxt;
  logic                               tx_busy_r, tx_busy_nxt;
  logic                               dout_r, dout_nxt;
  logic [spe_pkg::SER_W-1:0]          rx_word_r, rx_word_nxt;
  logic                               rx_valid_r, rx_valid_nxt;
  logic                               rej_r, rej_nxt;
  logic                               grant_r, grant_nxt;
  logic                               master_clear_pin_en_r, master_clear_pin_en_nxt;
  logic                               in_prog;

  assign in_prog = (state_r == spe_pkg::SPE_PROG_LV) ||
                   (state_r == spe_pkg::SPE_PROG_HV);

  // entry state machine
  always_comb begin
    state_nxt   = state_r;
    key_sh_nxt  = key_sh_r;
    key_cnt_nxt = key_cnt_r;
    rej_nxt     = 1'b0;
    unique case (state_r)
      spe_pkg::SPE_NORMAL: begin
        if (link.hv_high && !link.clk_level && !link.data_level) begin
          state_nxt = spe_pkg::SPE_PROG_HV;
        end else if (link.master_clear_pin_low && !link.hv_high &&
                     low_voltage_entry_enable_in) begin
          state_nxt   = spe_pkg::SPE_KEY_SHIFT;
          key_cnt_nxt = '0;
        end
      end
      spe_pkg::SPE_KEY_SHIFT: begin
        if (!link.master_clear_pin_low || !low_voltage_entry_enable_in) begin
          state_nxt = spe_pkg::SPE_NORMAL;
        end else if (link.clk_fall) begin
          key_sh_nxt  = {key_sh_r[spe_pkg::KEY_W-2:0],
                         link.data_level};
          key_cnt_nxt = key_cnt_r + 1'b1;
          if (key_cnt_r == spe_pkg::KEY_LAST) begin
            if ({key_sh_r[spe_pkg::KEY_W-2:0], link.data_level} ==
                spe_pkg::ENTRY_KEY) begin
              state_nxt = spe_pkg::SPE_PROG_LV;
            end else begin
              state_nxt = spe_pkg::SPE_KEY_FAIL;
              rej_nxt   = 1'b1;
            end
          end
        end
      end
      spe_pkg::SPE_KEY_FAIL: begin
        if (!link.master_clear_pin_low) begin
          state_nxt = spe_pkg::SPE_NORMAL;
        end
      end
      spe_pkg::SPE_PROG_LV: begin
        if (!link.master_clear_pin_low) begin
          state_nxt = spe_pkg::SPE_NORMAL;
        end
      end
      spe_pkg::SPE_PROG_HV: begin
        if (!link.hv_high) begin
          state_nxt = spe_pkg::SPE_NORMAL;
        end
      end
      default: state_nxt = spe_pkg::SPE_NORMAL;
    endcase
  end

  // session serial port: shift in on falling, drive out on rising edge
  always_comb begin
    rx_sh_nxt    = rx_sh_r;
    rx_cnt_nxt   = rx_cnt_r;
    rx_word_nxt  = rx_word_r;
    rx_valid_nxt = 1'b0;
    tx_sh_nxt    = tx_sh_r;
    tx_cnt_nxt   = tx_cnt_r;
    tx_busy_nxt  = tx_busy_r;
    dout_nxt     = dout_r;
    if (!in_prog) begin
      rx_cnt_nxt  = '0;
      tx_cnt_nxt  = '0;
      tx_busy_nxt = 1'b0;
      dout_nxt    = 1'b0;
    end else if (tx_busy_r) begin
      if (link.clk_rise) begin
        dout_nxt   = tx_sh_r[0];
        tx_sh_nxt  = {1'b0, tx_sh_r[spe_pkg::SER_W-1:1]};
        tx_cnt_nxt = tx_cnt_r + 1'b1;
      end
      if (link.clk_fall && tx_cnt_r == '0) begin
        tx_busy_nxt = 1'b0;
      end
    end else if (tx_load_in) begin
      tx_sh_nxt   = tx_word_in;
      tx_cnt_nxt  = '0;
      tx_busy_nxt = 1'b1;
      rx_cnt_nxt  = '0;
    end else if (link.clk_fall) begin
      rx_sh_nxt  = {link.data_level, rx_sh_r[spe_pkg::SER_W-1:1]};
      rx_cnt_nxt = rx_cnt_r + 1'b1;
      if (rx_cnt_r == spe_pkg::SER_LAST) begin
        rx_word_nxt  = {link.data_level, rx_sh_r[spe_pkg::SER_W-1:1]};
        rx_valid_nxt = 1'b1;
      end
    end
  end

  // configuration side effects
  always_comb begin
    master_clear_pin_en_nxt = low_voltage_entry_enable_in |
                  cfg_master_clear_pin_reset_enable_in;
    grant_nxt   = lve_clear_req_in &&
                  (state_r == spe_pkg::SPE_PROG_HV);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r    <= spe_pkg::SPE_NORMAL;
      key_sh_r   <= '0;
      key_cnt_r  <= '0;
      rej_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      key_sh_r   <= key_sh_nxt;
      key_cnt_r  <= key_cnt_nxt;
      rej_r      <= rej_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_sh_r    <= '0;
      rx_cnt_r   <= '0;
      rx_word_r  <= '0;
      rx_valid_r <= 1'b0;
      tx_sh_r    <= '0;
      tx_cnt_r   <= '0;
      tx_busy_r  <= 1'b0;
      dout_r     <= 1'b0;
    end else begin
      rx_sh_r    <= rx_sh_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      rx_word_r  <= rx_word_nxt;
      rx_valid_r <= rx_valid_nxt;
      tx_sh_r    <= tx_sh_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      tx_busy_r  <= tx_busy_nxt;
      dout_r     <= dout_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      master_clear_pin_en_r <= 1'b0;
      grant_r   <= 1'b0;
    end else begin
      master_clear_pin_en_r <= master_clear_pin_en_nxt;
      grant_r   <= grant_nxt;
    end
  end

  logic prog_r, lv_r, hv_r;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prog_r <= 1'b0;
      lv_r   <= 1'b0;
      hv_r   <= 1'b0;
    end else begin
      prog_r <= (state_nxt == spe_pkg::SPE_PROG_LV) ||
                (state_nxt == spe_pkg::SPE_PROG_HV);
      lv_r   <= state_nxt == spe_pkg::SPE_PROG_LV;
      hv_r   <= state_nxt == spe_pkg::SPE_PROG_HV;
    end
  end

  assign prog_data_pin_out     = dout_r;
  assign prog_data_pin_oe_out  = tx_busy_r;
  assign prog_mode_out         = prog_r;
  assign lv_session_out        = lv_r;
  assign hv_session_out        = hv_r;
  assign master_clear_pin_reset_enable_out = master_clear_pin_en_r;
  assign lve_clear_grant_out   = grant_r;
  assign key_reject_out        = rej_r;
  assign rx_word_out           = rx_word_r;
  assign rx_valid_out          = rx_valid_r;
  assign tx_busy_out           = tx_busy_r;
endmodule
`default_nettype wire

// ### tb/spe_entry_checker.sv
`timescale 1ns/100ps
`default_nettype none
module spe_entry_checker (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic prog_clock_pin_in,
  input wire logic prog_data_pin_in,
  input wire logic high_programming_voltage_level_in,
  input wire logic master_clear_pin_in,
  input wire logic low_voltage_entry_enable_in,
  input wire logic cfg_master_clear_pin_reset_enable_in,
  input wire logic lve_clear_req_in,
  input wire logic tx_load_in,
  input wire logic prog_data_pin_oe_out,
  input wire logic prog_mode_out,
  input wire logic lv_session_out,
  input wire logic hv_session_out,
  input wire logic master_clear_pin_reset_enable_out,
  input wire logic lve_clear_grant_out,
  input wire logic key_reject_out,
  input wire logic tx_busy_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_lv_held;
    (lv_session_out && !master_clear_pin_in) [*5];
  endsequence
  a_lv_gated:
    assert property ($rose(lv_session_out) |-> low_voltage_entry_enable_in)
      else $error("lv session without entry enable");
  a_master_clear_pin_forced:
    assert property (low_voltage_entry_enable_in |=> master_clear_pin_reset_enable_out)
      else $error("master clear reset not forced");
  a_master_clear_pin_cfg_off:
    assert property (!low_voltage_entry_enable_in && !cfg_master_clear_pin_reset_enable_in
      |=> !master_clear_pin_reset_enable_out) else $error("master clear reset stuck on");
  a_grant_cause:
    assert property (lve_clear_grant_out |-> $past(lve_clear_req_in)
      && $past(hv_session_out)) else $error("grant outside hv session");
  a_grant_given:
    assert property (lve_clear_req_in && hv_session_out |=>
      lve_clear_grant_out) else $error("grant missing in hv session");
  a_lv_holds:
    assert property (s_lv_held |=> lv_session_out)
      else $error("lv session dropped with master clear low");
  a_oe_in_session:
    assert property (prog_data_pin_oe_out |-> $past(prog_mode_out))
      else $error("data pin driven outside session");
  a_load_busy:
    assert property (tx_load_in && prog_mode_out && !tx_busy_out |=>
      tx_busy_out) else $error("readback not started");
  a_hv_entry:
    assert property ($rose(hv_session_out) |->
      $past(high_programming_voltage_level_in, 3) &&
      !$past(prog_clock_pin_in, 3) && !$past(prog_data_pin_in, 3))
      else $error("hv session without clean high-voltage entry");
  a_reject_pulse:
    assert property (key_reject_out |=> !key_reject_out && !prog_mode_out)
      else $error("reject not a single pulse");
endmodule
bind spe_entry spe_entry_checker i_spe_entry_checker (.*);
`default_nettype wire

// ### tb/spe_prog.sv
`timescale 1ns/100ps
`default_nettype none
module spe_prog (
  output var logic  pclk_out,
  output var logic  dat_out,
  output var logic  dat_oe_out,
  output var logic  master_clear_pin_out,
  output var logic  hv_out,
  input  wire logic dat_in
);
  initial begin
    {pclk_out, dat_out, hv_out} = 3'h0;
    {dat_oe_out, master_clear_pin_out} = 2'h3;
  end
  task automatic clk_bit(input logic b, output logic s);
    dat_out = b;
    #12 pclk_out = 1'b1;
    #24 s = dat_in;
    pclk_out = 1'b0;
    #12;
  endtask
  task automatic send(input logic [31:0] v, input int n);
    logic s;
    for (int i = n - 1; i >= 0; i--) clk_bit(v[i], s);
  endtask
  task automatic recv(output logic [15:0] w);
    dat_oe_out = 1'b0;
    for (int i = 0; i < 16; i++) clk_bit(1'b0, w[i]);
    dat_oe_out = 1'b1;
  endtask
  task automatic hv_enter();
    pclk_out = 1'b0;
    dat_out = 1'b0;
    #50 hv_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk, rst_n, lve, cfg, req, load;
  logic [15:0] txw, w, got;
  logic [31:0] r;
  logic [2:0]  seen;
  logic [15:0] exp_q[$];
  wire         pclk, hd, hoe, master_clear_pin, hvp, d_out, d_oe, mode, lv, hv;
  wire         mre, grant, rej, rxv, busy;
  wire  [15:0] rxw;
  wire         dat = d_oe ? d_out : hoe ? hd : ~d_out;
  int          errors = 0;
  int          checked = 0;
  int          seed = 39849;
  always #2.5 clk = ~clk;
  spe_entry i_spe_entry (.clk_in(clk), .resetn_in(rst_n),
    .prog_clock_pin_in(pclk), .prog_data_pin_in(dat),
    .master_clear_pin_in(master_clear_pin), .high_programming_voltage_level_in(hvp),
    .low_voltage_entry_enable_in(lve), .cfg_master_clear_pin_reset_enable_in(cfg),
    .lve_clear_req_in(req), .tx_load_in(load), .tx_word_in(txw),
    .prog_data_pin_out(d_out), .prog_data_pin_oe_out(d_oe),
    .prog_mode_out(mode), .lv_session_out(lv), .hv_session_out(hv),
    .master_clear_pin_reset_enable_out(mre), .lve_clear_grant_out(grant),
    .key_reject_out(rej), .rx_word_out(rxw), .rx_valid_out(rxv),
    .tx_busy_out(busy));
  spe_prog i_spe_prog (.pclk_out(pclk), .dat_out(hd), .dat_oe_out(hoe),
    .master_clear_pin_out(master_clear_pin), .hv_out(hvp), .dat_in(dat));
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task watch(input int n);
    seen = 3'h0;
    repeat (n) begin
      @(negedge clk);
      seen = seen | {rxv, rej, mode};
    end
  endtask
  task clear_req;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
  endtask
  initial begin
    #100000;
    errors++;
    conclude;
  end
  initial begin
    {clk, rst_n, lve, cfg, req, load} = 6'h0;
    txw = 16'h0;
    cyc(8);
    rst_n = 1'b1;
    cyc(4);
    check("mode", mode, 0);
    check("mre", mre, 0);
    for (int k = 0; k < 3; k++) begin
      lve = (k > 0);
      i_spe_prog.master_clear_pin_out = 1'b0;
      cyc(6);
      r = spe_pkg::ENTRY_KEY ^ (k == 1);
      i_spe_prog.send(r, 32);
      watch(12);
      check("reject", seen[1], k == 1);
      check("mode", seen[0], k == 2);
      if (k < 2) begin
        i_spe_prog.master_clear_pin_out = 1'b1;
        cyc(10);
      end
    end
    check("lv", lv, 1);
    check("mre", mre, 1);
    clear_req();
    check("grant", grant, 0);
    w = $random(seed);
    for (int i = 0; i < 16; i++) r[15-i] = w[i];
    exp_q.push_back(w);
    i_spe_prog.send(r, 16);
    watch(6);
    check("rxv", seen[2], 1);
    check("rx", rxw, exp_q.pop_front());
    txw = $random(seed);
    exp_q.push_back(txw);
    load = 1'b1;
    cyc(1);
    load = 1'b0;
    check("oe", d_oe, 1);
    check("busy", busy, 1);
    i_spe_prog.recv(got);
    check("tx", got, exp_q.pop_front());
    cyc(10);
    check("oe", d_oe, 0);
    i_spe_prog.master_clear_pin_out = 1'b1;
    cyc(12);
    check("mode", mode, 0);
    lve = 1'b0;
    cfg = $random(seed);
    i_spe_prog.hv_enter();
    cyc(10);
    check("hv", hv, 1);
    check("mre", mre, cfg);
    clear_req();
    check("grant", grant, 1);
    i_spe_prog.hv_out = 1'b0;
    cyc(10);
    check("mode", mode, 0);
    conclude;
  end
endmodule
`default_nettype wire
